// File: bench/fetch_model.sv
// fetch unit model that offers one opcode byte per request
`timescale 1ns/1ps
module fetch_model (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic go,
   input wire logic [7:0] go_code,
   output logic op_req,
   output logic [7:0] op_code
);
   // ==========================================================
   // request register
   logic op_req_nxt;
   logic [7:0] op_code_nxt;
   always_comb begin
      op_req_nxt = go;
      // byte only means something with op_req, so it churns otherwise
      op_code_nxt = go ? go_code : ~op_code;
   end
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         op_req <= 1'b0;
         op_code <= 8'h00;
      end else begin
         op_req <= op_req_nxt;
         op_code <= op_code_nxt;
      end
   end
endmodule

// File: bench/testbench.sv
// self-checking bench for the opcode decode slice
`timescale 1ns/1ps
module testbench
   import opdec_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic go = 1'b0;
   logic [7:0] go_code = 8'h00;
   logic op_req, op_ready, busy, done, pass_valid, flags_we;
   logic stack_pointer_we, irq_dma_block;
   logic [7:0] op_code, pass_code;
   logic [7:0] alu_result = 8'h00;
   flags_t flags_in = '0;
   flags_t flags_out, fx;
   logic [15:0] stack_pointer_in = 16'h0000;
   logic [15:0] stack_pointer_out;
   logic instr_retire = 1'b0;
   int fails = 0;
   int cmp_count = 0;
   int k;
   always #25 sys_clk = ~sys_clk;
   fetch_model fetch_model_i (.sys_clk, .rst, .go, .go_code, .op_req,
      .op_code);
   opcode_slice opcode_slice_i (.sys_clk, .rst, .op_req, .op_code,
      .alu_result, .flags_in, .stack_pointer_in, .instr_retire, .op_ready,
      .busy, .done, .pass_valid, .pass_code, .flags_out, .flags_we,
      .stack_pointer_out, .stack_pointer_we, .irq_dma_block);
   // ==========================================================
   // shared tasks
   task automatic complete_run();
      $display("fails=%0d cmp_count=%0d", fails, cmp_count);
      if (fails == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // offer one opcode; returns just after the edge that takes it
   task automatic launch(input logic [7:0] code);
      @(posedge sys_clk);
      go <= 1'b1;
      go_code <= code;
      @(posedge sys_clk);
      go <= 1'b0;
      @(posedge sys_clk);
      #1;
      k = 0;
      chk_bit(busy, 1'b1);
      chk_bit(op_ready, 1'b0);
   endtask
   task automatic await_done();
      while (done !== 1'b1) begin
         if (k == 20) begin
            fails++;
            complete_run();
         end
         @(posedge sys_clk);
         #1;
         k++;
      end
   endtask
   // ==========================================================
   // scenarios
   task automatic test_and();
      logic [7:0] ops [8] = '{8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57,
                             8'h58, 8'h59};
      int n [8] = '{5, 6, 6, 7, 6, 7, 7, 7};
      logic [7:0] res;
      for (int i = 0; i < 8; i++) begin
         res = (i % 3 == 0) ? 8'h00 : ((i % 3 == 1) ? 8'h80 : 8'h35);
         @(posedge sys_clk);
         alu_result <= res;
         flags_in <= '{c: i[0], z: res != 0, s: ~res[7], v: 1'b1, d: i[1],
                       h: i[2]};
         launch(ops[i]);
         await_done();
         fx = '{c: i[0], z: res == 0, s: res[7], v: 1'b0, d: i[1],
                h: i[2]};
         chk_val(16'(k), 16'(n[i]));
         chk_bit(flags_we, 1'b1);
         chk_val(16'(flags_out), 16'(fx));
         chk_bit(op_ready, 1'b1);
      end
   endtask
   task automatic test_carry_inv();
      for (int j = 0; j < 2; j++) begin
         @(posedge sys_clk);
         flags_in <= '{c: j[0], z: 1'b1, s: 1'b0, v: 1'b1, d: 1'b0, h: 1'b1};
         launch(8'hef);
         await_done();
         fx = '{c: ~j[0], z: 1'b1, s: 1'b0, v: 1'b1, d: 1'b0, h: 1'b1};
         chk_val(16'(k), 16'h0003);
         chk_bit(flags_we, 1'b1);
         chk_val(16'(flags_out), 16'(fx));
      end
   endtask
   task automatic test_call();
      logic [7:0] ops [2] = '{8'hd4, 8'hd6};
      logic [15:0] stack_vals [2] = '{16'h0001, 16'h8000};
      int n [2] = '{8, 6};
      for (int i = 0; i < 2; i++) begin
         @(posedge sys_clk);
         stack_pointer_in <= stack_vals[i];
         launch(ops[i]);
         // a second opcode offered while busy must be ignored
         @(posedge sys_clk);
         go <= 1'b1;
         go_code <= 8'hef;
         @(posedge sys_clk);
         go <= 1'b0;
         @(posedge sys_clk);
         #1;
         k = 3;
         await_done();
         chk_val(16'(k), 16'(n[i]));
         chk_bit(stack_pointer_we, 1'b1);
         chk_val(stack_pointer_out, stack_vals[i] - 16'h0002);
         chk_bit(flags_we, 1'b0);
         repeat (4) @(posedge sys_clk);
         #1;
         chk_bit(busy, 1'b0);
      end
   endtask
   task automatic test_guard();
      launch(8'h2f);
      await_done();
      chk_val(16'(k), 16'h0003);
      chk_bit(flags_we, 1'b0);
      @(posedge sys_clk);
      instr_retire <= 1'b1;
      #1;
      chk_bit(irq_dma_block, 1'b1);
      repeat (2) @(posedge sys_clk);
      #1;
      chk_bit(irq_dma_block, 1'b1);
      @(posedge sys_clk);
      instr_retire <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk_bit(irq_dma_block, 1'b0);
   endtask
   task automatic test_pass();
      logic [7:0] codes [6] = '{8'h00, 8'he2, 8'hd5, 8'hff, 8'h5a, 8'h2e};
      @(posedge sys_clk);
      go <= 1'b1;
      go_code <= codes[0];
      for (int m = 1; m < 10; m++) begin
         @(posedge sys_clk);
         if (m < 6) begin
            go_code <= codes[m];
         end else begin
            go <= 1'b0;
         end
         #1;
         chk_bit(flags_we | stack_pointer_we | busy, 1'b0);
         if (m >= 2 && m < 8) begin
            chk_bit(pass_valid, 1'b1);
            chk_val(16'(pass_code), 16'(codes[m - 2]));
         end else begin
            chk_bit(pass_valid, 1'b0);
         end
      end
      chk_bit(pass_valid, 1'b0);
   endtask
   // ==========================================================
   // main sequence
   initial begin
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk_bit(op_ready, 1'b1);
      chk_val(16'({busy, done, flags_we, stack_pointer_we, irq_dma_block}),
              16'h0000);
      chk_val(stack_pointer_out, 16'h0000);
      test_pass();
      test_and();
      test_carry_inv();
      test_call();
      test_guard();
      complete_run();
   end
endmodule

// File: logic/atomic_guard.sv
// holds off interrupt and dma requests for a run of instructions
`timescale 1ns/1ps
module atomic_guard
   import opdec_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic start,
   input wire logic instr_retire,
   output logic irq_dma_block
);

   // ==========================================================
   // instruction counter
   logic [1:0] left_r;
   logic [1:0] left_nxt;
   logic block_r;
   logic block_nxt;

   always_comb begin
      left_nxt = left_r;
      if (start) begin
         left_nxt = GUARD_COUNT; // RQ3
      end else if (instr_retire && left_r != 2'h0) begin
         left_nxt = left_r - 2'h1; // RQ3
      end
      // registered copy keeps the output straight from a flip-flop
      block_nxt = (left_nxt != 2'h0); // RQ3
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         left_r <= 2'h0;
         block_r <= 1'b0;
      end else begin
         left_r <= left_nxt;
         block_r <= block_nxt;
      end
   end

   assign irq_dma_block = block_r;

   // ==========================================================
   // checks
   a_guard_arms: assert property (@(posedge sys_clk) disable iff (rst) // RQ3
      start |=> irq_dma_block && left_r == GUARD_COUNT)
      else $error("guard not armed after start");
   a_guard_counts: assert property (@(posedge sys_clk) disable iff (rst) // RQ3
      !start && instr_retire && left_r == 2'h1 |=> !irq_dma_block)
      else $error("guard outlived its instruction count");

endmodule

// File: logic/opcode_slice.sv
// decode and execute control for the conjunction, guard, call, carry slice
`timescale 1ns/1ps
// Overview of operation
// [RQ1] opcodes 52..57 perform conjunction, set zero and sign from the result, clear overflow, keep carry, decimal and half-carry.
// [RQ2] opcodes 58 and 59 are the extended-address conjunction, 4 fetch and 3 execution cycles, same flag effects.
// [RQ3] opcode 2f blocks interrupt and dma requests for the next 3 instructions, changes no flag, takes 1 fetch and 2 execution cycles.
// [RQ4] opcodes d4 (2+6 cycles) and d6 (3+3 cycles) call a subroutine and lower the stack pointer by two.
// [RQ5] opcode ef inverts carry only, 1 fetch and 2 execution cycles.
// [RQ6] any other opcode is handed on unchanged and this slice leaves flags and program flow alone.
module opcode_slice
   import opdec_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic op_req,
   input wire logic [7:0] op_code,
   input wire logic [7:0] alu_result,
   input wire flags_t flags_in,
   input wire logic [15:0] stack_pointer_in,
   input wire logic instr_retire,
   output logic op_ready,
   output logic busy,
   output logic done,
   output logic pass_valid,
   output logic [7:0] pass_code,
   output flags_t flags_out,
   output logic flags_we,
   output logic [15:0] stack_pointer_out,
   output logic stack_pointer_we,
   output logic irq_dma_block
);

   // ==========================================================
   // sequence state
   typedef enum {
      S_IDLE,
      S_RUN
   } seq_state_t;

   seq_state_t state_r, state_nxt;
   op_kind_t kind_r, kind_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic op_ready_r, op_ready_nxt;
   logic busy_r, busy_nxt;
   logic done_r, done_nxt;
   logic pass_valid_r, pass_valid_nxt;
   logic [7:0] pass_code_r, pass_code_nxt;
   flags_t flags_r, flags_nxt;
   logic flags_we_r, flags_we_nxt;
   logic [15:0] stack_pointer_r, stack_pointer_nxt;
   logic stack_pointer_we_r, stack_pointer_we_nxt;
   logic guard_start;
   dec_t dec;

   always_comb begin
      dec = decode_op(op_code);
      state_nxt = state_r;
      kind_nxt = kind_r;
      cnt_nxt = cnt_r;
      op_ready_nxt = op_ready_r;
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      pass_valid_nxt = 1'b0;
      pass_code_nxt = pass_code_r;
      flags_nxt = flags_r;
      flags_we_nxt = 1'b0;
      stack_pointer_nxt = stack_pointer_r;
      stack_pointer_we_nxt = 1'b0;
      guard_start = 1'b0;
      case (state_r)
         S_IDLE: begin
            if (op_req) begin
               if (dec.claim) begin
                  state_nxt = S_RUN;
                  kind_nxt = dec.kind;
                  cnt_nxt = dec.cycles - 4'h1; // RQ2
                  op_ready_nxt = 1'b0;
                  busy_nxt = 1'b1;
               end else begin
                  pass_valid_nxt = 1'b1; // RQ6
                  pass_code_nxt = op_code; // RQ6
               end
            end
         end
         S_RUN: begin
            if (cnt_r != 4'h0) begin
               cnt_nxt = cnt_r - 4'h1;
            end else begin
               state_nxt = S_IDLE;
               op_ready_nxt = 1'b1;
               busy_nxt = 1'b0;
               done_nxt = 1'b1;
               case (kind_r)
                  K_AND: begin
                     flags_nxt = flags_in; // RQ1
                     flags_nxt.z = (alu_result == 8'h00); // RQ1
                     flags_nxt.s = alu_result[7]; // RQ1
                     flags_nxt.v = 1'b0; // RQ1
                     flags_we_nxt = 1'b1;
                  end
                  K_CARRY_INV: begin
                     flags_nxt = flags_in;
                     flags_nxt.c = ~flags_in.c; // RQ5
                     flags_we_nxt = 1'b1;
                  end
                  K_CALL: begin
                     stack_pointer_nxt = stack_pointer_in
                                         - CALL_STACK_DEC; // RQ4
                     stack_pointer_we_nxt = 1'b1;
                  end
                  K_ATOM: begin
                     guard_start = 1'b1; // RQ3
                  end
                  default: begin
                  end
               endcase
            end
         end
         default: begin
            state_nxt = S_IDLE;
            op_ready_nxt = 1'b1;
            busy_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_r <= S_IDLE;
         kind_r <= K_NONE;
         cnt_r <= 4'h0;
         op_ready_r <= 1'b1;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         pass_valid_r <= 1'b0;
         pass_code_r <= 8'h00;
         flags_r <= '0;
         flags_we_r <= 1'b0;
         stack_pointer_r <= 16'h0000;
         stack_pointer_we_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         kind_r <= kind_nxt;
         cnt_r <= cnt_nxt;
         op_ready_r <= op_ready_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
         pass_valid_r <= pass_valid_nxt;
         pass_code_r <= pass_code_nxt;
         flags_r <= flags_nxt;
         flags_we_r <= flags_we_nxt;
         stack_pointer_r <= stack_pointer_nxt;
         stack_pointer_we_r <= stack_pointer_we_nxt;
      end
   end

   // ==========================================================
   // guard counter
   atomic_guard u_guard (
      .sys_clk(sys_clk),
      .rst(rst),
      .start(guard_start),
      .instr_retire(instr_retire),
      .irq_dma_block(irq_dma_block)
   );

   assign op_ready = op_ready_r;
   assign busy = busy_r;
   assign done = done_r;
   assign pass_valid = pass_valid_r;
   assign pass_code = pass_code_r;
   assign flags_out = flags_r;
   assign flags_we = flags_we_r;
   assign stack_pointer_out = stack_pointer_r;
   assign stack_pointer_we = stack_pointer_we_r;

   // ==========================================================
   // checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   a_and_flags: assert property ( // RQ1
      done && flags_we && $past(kind_r) == K_AND |->
      !flags_out.v && flags_out.z == ($past(alu_result) == 8'h00)
      && flags_out.s == $past(alu_result[7])
      && flags_out.c == $past(flags_in.c)
      && flags_out.h == $past(flags_in.h))
      else $error("conjunction flags wrong");
   a_ext_and_timing: assert property ( // RQ2
      op_req && op_ready && op_code == OP_EXT_AND_EXT |=>
      busy [*7] ##1 (done && flags_we))
      else $error("extended conjunction took wrong time");
   a_atom_timing: assert property ( // RQ3
      op_req && op_ready && op_code == OP_ATOM |->
      ##4 (done && !flags_we && irq_dma_block) ##1 irq_dma_block)
      else $error("guard instruction timing or flags wrong");
   a_call_stack_drop: assert property ( // RQ4
      op_req && op_ready && op_code == OP_CALL_IRR |->
      ##9 (stack_pointer_we && !flags_we
      && stack_pointer_out == $past(stack_pointer_in) - CALL_STACK_DEC))
      else $error("call did not lower stack pointer by two");
   a_carry_inv_flags: assert property ( // RQ5
      op_req && op_ready && op_code == OP_CARRY_INV |->
      ##4 (flags_we && flags_out.c == !$past(flags_in.c)
      && flags_out.z == $past(flags_in.z)))
      else $error("carry invert wrong");
   a_pass_unclaimed: assert property ( // RQ6
      op_req && op_ready && !dec.claim |=>
      pass_valid && pass_code == $past(op_code) && !busy && !flags_we
      && !stack_pointer_we)
      else $error("unclaimed opcode not handed on");
   a_ready_busy: assert property (
      op_ready != busy)
      else $error("ready and busy overlap");

   c_and_done: cover property (done && flags_we && !flags_out.v);
   c_call_done: cover property (stack_pointer_we);
   c_guard_on: cover property (irq_dma_block && instr_retire);
   c_pass: cover property (pass_valid);

endmodule

// File: shared/opdec_pkg.sv
// shared types, opcodes and cycle counts for the opcode decode slice
package opdec_pkg;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic c;
      logic z;
      logic s;
      logic v;
      logic d;
      logic h;
   } flags_t;

   typedef enum logic [2:0] {
      K_NONE,
      K_AND,
      K_ATOM,
      K_CALL,
      K_CARRY_INV
   } op_kind_t;

   typedef struct packed {
      logic claim;
      op_kind_t kind;
      logic [3:0] cycles;
   } dec_t;

   // ==========================================================
   // opcodes
   localparam logic [7:0] OP_AND_FIRST = 8'h52;
   localparam logic [7:0] OP_AND_LONG_FIRST = 8'h54;
   localparam logic [7:0] OP_AND_LAST = 8'h57;
   localparam logic [7:0] OP_EXT_AND_EXT = 8'h58;
   localparam logic [7:0] OP_EXT_AND_IMM = 8'h59;
   localparam logic [7:0] OP_ATOM = 8'h2f;
   localparam logic [7:0] OP_CALL_IRR = 8'hd4;
   localparam logic [7:0] OP_CALL_DIRECT = 8'hd6;
   localparam logic [7:0] OP_CARRY_INV = 8'hef;

   // ==========================================================
   // fetch and execution cycles
   localparam logic [3:0] FETCH_AND_SHORT = 4'h2;
   localparam logic [3:0] FETCH_AND_LONG = 4'h3;
   localparam logic [3:0] EXEC_AND_DIRECT = 4'h3;
   localparam logic [3:0] EXEC_AND_INDIRECT = 4'h4;
   localparam logic [3:0] FETCH_EXT_AND = 4'h4;
   localparam logic [3:0] EXEC_EXT_AND = 4'h3;
   localparam logic [3:0] FETCH_ATOM = 4'h1;
   localparam logic [3:0] EXEC_ATOM = 4'h2;
   localparam logic [3:0] FETCH_CALL_IRR = 4'h2;
   localparam logic [3:0] EXEC_CALL_IRR = 4'h6;
   localparam logic [3:0] FETCH_CALL_DIRECT = 4'h3;
   localparam logic [3:0] EXEC_CALL_DIRECT = 4'h3;
   localparam logic [3:0] FETCH_CARRY_INV = 4'h1;
   localparam logic [3:0] EXEC_CARRY_INV = 4'h2;

   // ==========================================================
   // other values
   localparam logic [1:0] GUARD_COUNT = 2'h3;
   localparam logic [15:0] CALL_STACK_DEC = 16'h0002;

   // ==========================================================
   // opcode classification
   function automatic dec_t decode_op(input logic [7:0] op);
      dec_t d;
      d = '{claim: 1'b1, kind: K_NONE, cycles: 4'h0};
      if (op >= OP_AND_FIRST && op <= OP_AND_LAST) begin
         d.kind = K_AND;
         d.cycles = ((op < OP_AND_LONG_FIRST) ? FETCH_AND_SHORT
                     : FETCH_AND_LONG)
                    + (op[0] ? EXEC_AND_INDIRECT : EXEC_AND_DIRECT);
      end else begin
         case (op)
            OP_EXT_AND_EXT, OP_EXT_AND_IMM: begin
               d.kind = K_AND;
               d.cycles = FETCH_EXT_AND + EXEC_EXT_AND;
            end
            OP_ATOM: begin
               d.kind = K_ATOM;
               d.cycles = FETCH_ATOM + EXEC_ATOM;
            end
            OP_CALL_IRR: begin
               d.kind = K_CALL;
               d.cycles = FETCH_CALL_IRR + EXEC_CALL_IRR;
            end
            OP_CALL_DIRECT: begin
               d.kind = K_CALL;
               d.cycles = FETCH_CALL_DIRECT + EXEC_CALL_DIRECT;
            end
            OP_CARRY_INV: begin
               d.kind = K_CARRY_INV;
               d.cycles = FETCH_CARRY_INV + EXEC_CARRY_INV;
            end
            default: begin
               d.claim = 1'b0;
            end
         endcase
      end
      return d;
   endfunction

endpackage
